/* heater_power_control.sv */
// Purpose: Relay drive for one heat-trace circuit, set up over Wishbone.
// Assumes: Classic Wishbone slave, temp_i synchronous to clk_i.
// Notes:   Long counts are parameters so that simulation can shorten them.
`default_nettype none
module heater_power_control
    import heater_power_pkg::*;
#(
    parameter logic [35:0] SEC_CYC_P  = SEC_CYC,
    parameter logic [35:0] SLOW_CYC_P = SLOW_CYC,
    parameter logic [35:0] RAMP_CYC_P = RAMP_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    input  wire logic signed [15:0] temp_i,
    output logic                    heater_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        mode_t              mode;
        logic               solid_state_switch;
        logic               line;
        logic [6:0]         clamp;
        logic signed [15:0] maintain_setpoint;
        logic signed [15:0] amb;
        logic signed [15:0] tmax;
        logic signed [15:0] low_temp_alarm_setpoint;
        logic signed [15:0] control_band;
        ss_state_t          ss;
        logic [35:0]        per_cnt;
        logic [35:0]        ramp_cnt;
        logic [6:0]         pct_lat;
        logic               heater;
        logic               ack;
        logic [31:0]        dat;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // Byte-lane merge for the 16-bit setpoint registers
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // ****************************************************************
    // Derived values
    // ****************************************************************
    logic signed [16:0] num;
    logic signed [16:0] den;
    logic signed [16:0] band_top;
    logic signed [16:0] upper;
    logic [23:0]        quot;
    logic [6:0]         pct;
    logic               prop_mode;
    logic               soft_active;
    logic               hot;
    logic [35:0]        period;
    logic               per_wrap;
    logic               onoff_on;
    logic               prop_on;
    logic               ramp_on;
    logic               cfg_err;
    logic [63:0]        ramp_lhs;
    logic [63:0]        ramp_rhs;

    // Proportional percentage with saturation and measurement floor
    always_comb begin
        num  = 17'(s_r.maintain_setpoint) - 17'(temp_i);
        den  = 17'(s_r.maintain_setpoint) - 17'(s_r.amb);
        quot = 24'h0;
        if (temp_i > s_r.maintain_setpoint) begin
            pct = 7'h00;
        end else if (temp_i <= s_r.amb || den <= 17'sh0) begin
            pct = PCT_FULL;
        end else begin
            quot = (24'(unsigned'(num)) * 24'h64) / 24'(unsigned'(den));
            pct  = quot[6:0];
            // Keeps heater and leakage currents large enough to measure
            if (pct != 7'h00 && pct < PCT_FLOOR) begin
                pct = PCT_FLOOR;
            end
        end
    end

    // Mode decode and thresholds
    always_comb begin
        prop_mode   = (s_r.mode == ambient_proportional_mode) ||
                      (s_r.mode == slow_relay_proportional_mode);
        // A mechanical relay cannot switch fast enough for the ramp
        soft_active = (s_r.mode == mode_soft_start) && s_r.solid_state_switch &&
                      (s_r.clamp < PCT_FULL);
        cfg_err     = (s_r.mode == mode_soft_start) && !s_r.solid_state_switch;
        band_top    = 17'(s_r.maintain_setpoint) + 17'(s_r.control_band);
        hot         = 17'(temp_i) >= band_top;
        upper       = s_r.line ? 17'(s_r.tmax) : 17'(s_r.maintain_setpoint);
        if (prop_mode && (!s_r.solid_state_switch ||
                          s_r.mode == slow_relay_proportional_mode)) begin
            period = SLOW_CYC_P;
        end else begin
            period = SEC_CYC_P;
        end
        per_wrap = s_r.per_cnt >= period - 36'h1;
    end

    // Output decisions for each method
    always_comb begin
        // Hysteresis: hold the last state between maintain and upper
        if (17'(temp_i) < 17'(s_r.maintain_setpoint)) begin
            onoff_on = 1'b1;
        end else if (17'(temp_i) > upper) begin
            onoff_on = 1'b0;
        end else begin
            onoff_on = s_r.heater;
        end
        // Cycle on-time follows the percent latched at its start
        if (temp_i > s_r.maintain_setpoint) begin
            prop_on = 1'b0;
        end else if (temp_i <= s_r.amb) begin
            prop_on = 1'b1;
        end else begin
            prop_on = (48'(s_r.per_cnt) * 48'h64) <
                      (48'(s_r.pct_lat) * 48'(period));
        end
        // Duty climbs linearly from clamp to full across the ramp
        ramp_lhs = 64'(s_r.per_cnt) * 64'h64 * 64'(RAMP_CYC_P);
        ramp_rhs = (64'(s_r.clamp) * 64'(RAMP_CYC_P) +
                    64'(PCT_FULL - s_r.clamp) * 64'(s_r.ramp_cnt)) * 64'(SEC_CYC_P);
        ramp_on  = ramp_lhs < ramp_rhs;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;

        // Wishbone slave: one-cycle ack, dropped the cycle after
        s_nxt.ack = cyc_i && stb_i && !s_r.ack;
        s_nxt.dat = 32'h0;
        if (cyc_i && stb_i && !s_r.ack) begin
            if (we_i) begin
                case (adr_i)
                    REG_CTRL: begin
                        if (sel_i[0]) begin
                            s_nxt.mode = mode_t'(dat_i[CTRL_MODE_LSB +: 3]);
                            s_nxt.solid_state_switch = dat_i[CTRL_SOLID_STATE_BIT];
                            s_nxt.line = dat_i[CTRL_LINE_BIT];
                        end
                        if (sel_i[1]) begin
                            s_nxt.clamp = dat_i[CTRL_CLAMP_LSB +: 7];
                        end
                    end
                    REG_MAINTAIN: s_nxt.maintain_setpoint =
                        merge16(s_r.maintain_setpoint, dat_i, sel_i);
                    REG_MIN_AMB:  s_nxt.amb  = merge16(s_r.amb, dat_i, sel_i);
                    REG_MAX_TEMP: s_nxt.tmax = merge16(s_r.tmax, dat_i, sel_i);
                    REG_LOW_TEMP: s_nxt.low_temp_alarm_setpoint =
                        merge16(s_r.low_temp_alarm_setpoint, dat_i, sel_i);
                    REG_BAND:     s_nxt.control_band = merge16(s_r.control_band, dat_i, sel_i);
                    default: begin
                    end
                endcase
            end else begin
                case (adr_i)
                    REG_CTRL: begin
                        s_nxt.dat = {17'h0, s_r.clamp, 3'h0, s_r.line,
                                     s_r.solid_state_switch, s_r.mode};
                    end
                    REG_MAINTAIN: s_nxt.dat = {16'h0, s_r.maintain_setpoint};
                    REG_MIN_AMB:  s_nxt.dat = {16'h0, s_r.amb};
                    REG_MAX_TEMP: s_nxt.dat = {16'h0, s_r.tmax};
                    REG_LOW_TEMP: s_nxt.dat = {16'h0, s_r.low_temp_alarm_setpoint};
                    REG_BAND:     s_nxt.dat = {16'h0, s_r.control_band};
                    REG_STATUS: begin
                        s_nxt.dat = {temp_i, 1'b0, pct, 4'h0, cfg_err, s_r.ss, s_r.heater};
                    end
                    default: s_nxt.dat = 32'h0;
                endcase
            end
        end

        // Period counter shared by proportional cycle and soft sub-period
        if (per_wrap) begin
            s_nxt.per_cnt = 36'h0;
            s_nxt.pct_lat = pct;
        end else begin
            s_nxt.per_cnt = s_r.per_cnt + 36'h1;
        end

        // Soft start sequencing
        if (!soft_active) begin
            s_nxt.ss       = ss_full;
            s_nxt.ramp_cnt = 36'h0;
        end else begin
            case (s_r.ss)
                ss_full: begin
                    if (hot) begin
                        s_nxt.ss = ss_off;
                    end else if (temp_i >= s_r.low_temp_alarm_setpoint) begin
                        s_nxt.ss       = ss_ramp;
                        s_nxt.ramp_cnt = 36'h0;
                        s_nxt.per_cnt  = 36'h0;
                    end
                end
                ss_ramp: begin
                    if (hot) begin
                        s_nxt.ss = ss_off;
                    end else if (s_r.ramp_cnt >= RAMP_CYC_P - 36'h1) begin
                        s_nxt.ss = ss_cont;
                    end else begin
                        s_nxt.ramp_cnt = s_r.ramp_cnt + 36'h1;
                    end
                end
                ss_cont: begin
                    if (hot) begin
                        s_nxt.ss = ss_off;
                    end
                end
                ss_off: begin
                    // Restart from the clamp, not from full power
                    if (temp_i <= s_r.maintain_setpoint) begin
                        s_nxt.ss       = ss_ramp;
                        s_nxt.ramp_cnt = 36'h0;
                        s_nxt.per_cnt  = 36'h0;
                    end
                end
                default: s_nxt.ss = ss_full;
            endcase
        end

        // Relay drive
        if (soft_active) begin
            case (s_r.ss)
                ss_full: s_nxt.heater = !hot;
                ss_ramp: s_nxt.heater = !hot && ramp_on;
                ss_cont: s_nxt.heater = !hot;
                ss_off:  s_nxt.heater = 1'b0;
                default: s_nxt.heater = 1'b0;
            endcase
        end else if (prop_mode) begin
            s_nxt.heater = prop_on;
        end else if (s_r.mode == mode_on_off || s_r.mode == mode_soft_start) begin
            s_nxt.heater = onoff_on;
        end else begin
            s_nxt.heater = 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r          <= '0;
            s_r.mode     <= mode_off;
            s_r.clamp    <= RST_CLAMP;
            s_r.maintain_setpoint       <= RST_TEMP;
            s_r.amb                     <= RST_TEMP;
            s_r.tmax                    <= RST_TEMP;
            s_r.low_temp_alarm_setpoint <= RST_TEMP;
            s_r.control_band            <= RST_TEMP;
            s_r.ss       <= ss_full;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign heater_o = s_r.heater;
    assign ack_o    = s_r.ack;
    assign dat_o    = s_r.dat;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking chk_clk @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    prop_hot_off_a: assert property (prop_mode &&
                                     temp_i > s_r.maintain_setpoint |=> !heater_o)
        else $error("heater on above maintain in proportional mode");
    prop_cold_on_a: assert property (prop_mode && temp_i <= s_r.amb &&
                                     temp_i <= s_r.maintain_setpoint |=> heater_o)
        else $error("heater off at minimum ambient");
    pct_range_a: assert property (pct == 7'h00 || (pct >= PCT_FLOOR && pct <= PCT_FULL))
        else $error("power percent outside floor and full");
    pct_half_a: assert property (temp_i > s_r.amb && den > 17'sh0 &&
                                 temp_i < s_r.maintain_setpoint &&
                                 (s_r.maintain_setpoint - temp_i) * 2 == den |-> pct == 7'h32)
        else $error("midpoint percent is not fifty");
    onoff_low_a: assert property (s_r.mode == mode_on_off &&
                                  temp_i < s_r.maintain_setpoint |=> heater_o)
        else $error("on-off heater off below maintain");
    onoff_high_a: assert property (s_r.mode == mode_on_off && 17'(temp_i) > upper
                                   |=> !heater_o)
        else $error("on-off heater on above upper threshold");
    ss_band_off_a: assert property (soft_active && hot &&
                                    temp_i > s_r.maintain_setpoint
                                    |=> !heater_o && s_r.ss == ss_off)
        else $error("soft start not off at maintain plus band");
    ss_low_on_a: assert property (soft_active && s_r.ss == ss_full && !hot &&
                                  temp_i < s_r.low_temp_alarm_setpoint
                                  |=> heater_o && s_r.ss == ss_full)
        else $error("soft start not full on below low alarm");
    ss_off_hold_a: assert property (soft_active && s_r.ss == ss_off &&
                                    temp_i > s_r.maintain_setpoint
                                    |=> s_r.ss == ss_off && !heater_o)
        else $error("soft start left off state above maintain");
    ramp_done_a: assert property (soft_active && s_r.ss == ss_ramp && !hot &&
                                  s_r.ramp_cnt == RAMP_CYC_P - 36'h1 |=> s_r.ss == ss_cont)
        else $error("ramp did not finish at its length");
    mech_no_soft_a: assert property (s_r.mode == mode_soft_start &&
                                     !s_r.solid_state_switch |=> s_r.ss == ss_full)
        else $error("soft ramp ran on a mechanical relay");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");

endmodule
`default_nettype wire

/* heater_power_pkg.sv */
// Purpose: Shared constants and types for the heater power controller.
// Assumes: 10 MHz system clock; temperatures are signed 16-bit counts.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package heater_power_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint unsigned CLK_HZ         = 64'h0000_0000_0098_9680; // 10 MHz
    localparam longint unsigned SOFT_PERIOD_S  = 64'h1;   // Soft-start sub-period, s
    localparam longint unsigned SLOW_CYCLE_MIN = 64'h14;  // Relay cycle, 20 min
    localparam longint unsigned SEC_PER_MIN    = 64'h3c;
    localparam longint unsigned RAMP_S         = 64'h5a;  // Ramp length, 90 s
    localparam logic [35:0] SEC_CYC  = 36'(SOFT_PERIOD_S * CLK_HZ);
    localparam logic [35:0] SLOW_CYC = 36'(SLOW_CYCLE_MIN * SEC_PER_MIN * CLK_HZ);
    localparam logic [35:0] RAMP_CYC = 36'(RAMP_S * CLK_HZ);

    // ****************************************************************
    // Percent figures
    // ****************************************************************
    localparam logic [6:0] PCT_FULL  = 7'h64; // 100 %
    localparam logic [6:0] PCT_FLOOR = 7'h08; // 8 %

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_MAINTAIN = 8'h04;
    localparam logic [7:0] REG_MIN_AMB  = 8'h08;
    localparam logic [7:0] REG_MAX_TEMP = 8'h0c;
    localparam logic [7:0] REG_LOW_TEMP = 8'h10;
    localparam logic [7:0] REG_BAND     = 8'h14;
    localparam logic [7:0] REG_STATUS   = 8'h18;

    // Control fields
    localparam int CTRL_MODE_LSB        = 0;
    localparam int CTRL_SOLID_STATE_BIT = 3;
    localparam int CTRL_LINE_BIT        = 4;
    localparam int CTRL_CLAMP_LSB       = 8;

    // Reset values
    localparam logic [6:0]         RST_CLAMP = 7'h64;
    localparam logic signed [15:0] RST_TEMP  = 16'sh0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        mode_off                     = 3'b000,
        mode_on_off                  = 3'b001,
        mode_soft_start              = 3'b010,
        ambient_proportional_mode    = 3'b011,
        slow_relay_proportional_mode = 3'b100
    } mode_t;

    typedef enum logic [1:0] {
        ss_full = 2'b00,
        ss_ramp = 2'b01,
        ss_cont = 2'b10,
        ss_off  = 2'b11
    } ss_state_t;

endpackage
`default_nettype wire

/* heater_relay_model.sv */
// Purpose: Behavioural relay on the heater drive, counting energised cycles.
// Assumes: Coil input is a registered level synchronous to clk_i.
// Notes:   A real relay cannot report duty; the counter is for the bench only.
`default_nettype none
module heater_relay_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        coil_i,
    input  wire logic        clear_i,
    output logic      [31:0] on_count_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Duty counter
    // ****************************************************************
    // Counts energised coil cycles; clear restarts a measuring window
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            on_count_o <= 32'h0;
        end else begin
            on_count_o <= on_count_o + {31'h0, coil_i};
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the heater power controller.
// Assumes: Short periods: 1 s = 100 cycles, relay cycle 1000, ramp 500.
// Notes:   Duty is measured by the relay model over a window of cycles.
`default_nettype none
module tb_top
    import heater_power_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic signed [15:0] temp_i = 16'sh0;
    logic        heater_o;
    logic        clear_i = 1'b0;
    logic [31:0] on_count;
    int          num_errors  = 0;
    int          check_count = 0;

    // ****************************************************************
    // Design, relay and clock
    // ****************************************************************
    heater_power_control #(.SEC_CYC_P(36'h64), .SLOW_CYC_P(36'h3e8), .RAMP_CYC_P(36'h1f4))
        u_heater_power_control (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .temp_i(temp_i), .heater_o(heater_o));
    heater_relay_model u_heater_relay_model (.clk_i(clk_i), .rst_i(rst_i), .coil_i(heater_o),
        .clear_i(clear_i), .on_count_o(on_count));

    always #50 clk_i = ~clk_i;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; holds everything until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("Error at %0t: no bus answer", $time);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask

    task automatic setup(input logic [31:0] ctrl, input logic [15:0] maintain,
                         input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] band);
        wb_write(REG_MAINTAIN, {16'h0, maintain});
        wb_write(REG_MIN_AMB, {16'h0, lo});
        wb_write(REG_LOW_TEMP, {16'h0, lo});
        wb_write(REG_MAX_TEMP, {16'h0, hi});
        wb_write(REG_BAND, {16'h0, band});
        wb_write(REG_CTRL, ctrl);
    endtask

    // Sets temperature, lets it settle, then measures on-cycles in a window
    task automatic duty(input logic signed [15:0] t, input int settle, input int win,
                        output logic [31:0] cnt);
        temp_i <= t;
        repeat (settle + 1) @(posedge clk_i);
        clear_i <= 1'b1;
        @(posedge clk_i);
        clear_i <= 1'b0;
        // One extra edge: the count of the last window cycle shows after it
        repeat (win + 1) @(posedge clk_i);
        cnt = on_count;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_regs();
        logic [31:0] q;
        wb_cycle(1'b0, REG_CTRL, 32'h0, q);
        check(q, 32'h0000_6400);
        wb_write(REG_MAINTAIN, 32'hffff_0032);
        wb_cycle(1'b0, REG_MAINTAIN, 32'h0, q);
        check(q, 32'h0000_0032);
        wb_write(8'h1c, 32'h0000_1234);
        wb_cycle(1'b0, 8'h1c, 32'h0, q);
        check(q, 32'h0);
        // Mode off after reset keeps the relay dropped even below maintain
        check({31'h0, heater_o}, 32'h0);
        $display("test_regs done");
    endtask

    task automatic test_on_off();
        logic [31:0] c;
        setup(32'h0000_6401, 16'h0032, 16'h0000, 16'h0050, 16'h0014);
        duty(16'sh0028, 3, 50, c);
        check(c, 32'd50);
        duty(16'sh003c, 3, 50, c);
        check(c, 32'd0);
        wb_write(REG_CTRL, 32'h0000_6411);
        duty(16'sh0028, 3, 50, c);
        duty(16'sh003c, 3, 50, c);
        check(c, 32'd50);
        duty(16'sh005a, 3, 50, c);
        check(c, 32'd0);
        $display("test_on_off done");
    endtask

    task automatic test_prop();
        logic [31:0] c;
        setup(32'h0000_640b, 16'h0028, 16'hffd8, 16'h0050, 16'h0014);
        duty(16'sh0000, 200, 100, c);
        check(c, 32'd50);
        duty(16'sh002d, 200, 100, c);
        check(c, 32'd0);
        duty(16'shffd8, 200, 100, c);
        check(c, 32'd100);
        duty(16'sh0025, 200, 100, c);
        check(c, 32'd8);
        duty(16'shff9c, 200, 100, c);
        check(c, 32'd100);
        wb_write(REG_CTRL, 32'h0000_640c);
        duty(16'sh0000, 2000, 1000, c);
        check(c, 32'd500);
        $display("test_prop done");
    endtask

    task automatic test_soft();
        logic [31:0] c;
        setup(32'h0000_140a, 16'h0032, 16'h000a, 16'h0050, 16'h0014);
        duty(16'sh0000, 3, 100, c);
        check(c, 32'd100);
        duty(16'sh0014, 0, 100, c);
        check(32'(c >= 18 && c <= 32), 32'h1);
        duty(16'sh0014, 500, 100, c);
        check(c, 32'd100);
        duty(16'sh0046, 3, 50, c);
        check(c, 32'd0);
        duty(16'sh003c, 3, 50, c);
        check(c, 32'd0);
        duty(16'sh0032, 0, 100, c);
        check(32'(c >= 18 && c <= 32), 32'h1);
        wb_write(REG_CTRL, 32'h0000_640a);
        duty(16'sh003c, 3, 50, c);
        check(c, 32'd0);
        wb_write(REG_CTRL, 32'h0000_1402);
        duty(16'sh0028, 3, 50, c);
        check(c, 32'd50);
        wb_cycle(1'b0, REG_STATUS, 32'h0, c);
        check({31'h0, c[3]}, 32'h1);
        $display("test_soft done");
    endtask

    // ****************************************************************
    // Verdict, watchdog and main sequence
    // ****************************************************************
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 6000 cycles; allow ten times that
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_regs();
        test_on_off();
        test_prop();
        test_soft();
        wrap_up();
    end
endmodule
`default_nettype wire
